// *** ips_pkg.sv ***
// Shared constants, types and register map of the imager power-mode sequencer.
package ips_pkg;

  // Core clock rate.
  localparam int unsigned CLK_HZ            = 25_000_000;
  localparam int unsigned CYC_PER_MS        = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US        = CLK_HZ / 1_000_000;

  // Times in their own units, as figures.
  localparam int unsigned GLITCH_WINDOW_MS  = 2000;
  localparam int unsigned STANDBY_EXIT_US   = 300;
  localparam int unsigned POWEROFF_EXIT_MS  = 1100;
  localparam int unsigned TRIG_IND_US       = 5600;
  localparam int unsigned WAKE_IND_US       = 5000;
  localparam int unsigned MS_TICK_MS        = 1;

  // The same times as counts of core clock cycles.
  localparam int unsigned GLITCH_WINDOW_CYC = CYC_PER_MS * GLITCH_WINDOW_MS;
  localparam int unsigned STANDBY_EXIT_CYC  = CYC_PER_US * STANDBY_EXIT_US;
  localparam int unsigned POWEROFF_EXIT_CYC = CYC_PER_MS * POWEROFF_EXIT_MS;
  localparam int unsigned TRIG_IND_CYC      = CYC_PER_US * TRIG_IND_US;
  localparam int unsigned WAKE_IND_CYC      = CYC_PER_US * WAKE_IND_US;
  localparam int unsigned MS_TICK_CYC       = CYC_PER_MS * MS_TICK_MS;

  // Register byte offsets.
  localparam logic [7:0]  REG_CTRL          = 8'h00;
  localparam logic [7:0]  REG_IDLE_TO       = 8'h04;
  localparam logic [7:0]  REG_SERIAL_TO     = 8'h08;
  localparam logic [7:0]  REG_TRIG_TO       = 8'h0C;
  localparam logic [7:0]  REG_STATUS        = 8'h10;

  // Field positions.
  localparam int unsigned CTRL_MANUAL_BIT   = 0;
  localparam int unsigned STAT_MODE_LSB     = 0;
  localparam int unsigned STAT_READY_BIT    = 3;
  localparam int unsigned STAT_IND_BIT      = 4;

  // Values after reset; time-outs are in milliseconds.
  localparam logic        CTRL_MANUAL_RST   = 1'b1;
  localparam logic [15:0] IDLE_TO_RST       = 16'h03E8;
  localparam logic [15:0] SERIAL_TO_RST     = 16'h0BB8;
  localparam logic [15:0] TRIG_TO_RST       = 16'h0BB8;

  // Power modes of the engine.
  typedef enum logic [2:0] {
    PM_POWERUP,
    PM_ACTIVE,
    PM_IDLE,
    PM_STANDBY,
    PM_STBY_EXIT,
    PM_POWER_OFF,
    PM_OFF_EXIT
  } ips_mode_e;

  // Register access request from software.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ips_bus_s;

endpackage

// *** ips_power_mode_sequencer.sv ***
// Power-mode sequencer with power-off indicator and register port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Supply fault within 2 s of power-up sends the engine to Power Off.
// - In Power Off, low scan or wake request powers the engine back up.
// - In Power Off, a serial host command also powers the engine up.
// - Leaving Standby on a request, operational within 300 us.
// - Leaving Power Off on a request, ready to scan after 1.1 s.
// - Scan request in Power Off drops the indicator 5.6 ms later.
// - Wake request in Power Off drops the indicator 5 ms later.
// - Indicator rises once time-outs after release of both inputs expire.
// - Idle after idle time-out; Standby after idle plus serial time-outs.
// - Power Off from Standby only in manual mode, after all three time-outs expire.
// - Indicator stays high for the whole of Power Off.
module ips_power_mode_sequencer
  import ips_pkg::*;
#(
  parameter int unsigned GLITCH_CYC   = GLITCH_WINDOW_CYC,
  parameter int unsigned STBY_EXIT_CYC = STANDBY_EXIT_CYC,
  parameter int unsigned OFF_EXIT_CYC = POWEROFF_EXIT_CYC,
  parameter int unsigned TRIG_DLY_CYC = TRIG_IND_CYC,
  parameter int unsigned WAKE_DLY_CYC = WAKE_IND_CYC,
  parameter int unsigned MS_CYC       = MS_TICK_CYC
) (
  input  wire logic     core_clk,
  input  wire logic     reset_n,
  input  wire ips_bus_s bus_req,
  output logic [31:0]   rd_data,
  input  wire logic     scan_request_n,
  input  wire logic     wake_request_n,
  input  wire logic     supply_fault,
  input  wire logic     serial_cmd_valid,
  output logic          power_off_indicator,
  output logic          ready_to_scan,
  output logic [2:0]    power_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [2:0]  scan_sync_ff;
  logic [2:0]  wake_sync_ff;
  logic [2:0]  fault_sync_ff;
  logic        scan_n_ff;
  logic        wake_n_ff;
  logic        fault_ff;
  logic [31:0] div_cnt_ff;
  logic        ms_tick_ff;
  logic [31:0] quiet_ms_ff;
  logic [31:0] seq_cnt_ff;
  logic        trig_wake_ff;
  ips_mode_e   state_ff;
  ips_mode_e   nxt_state;
  logic        manual_mode_ff;
  logic [15:0] idle_to_ff;
  logic [15:0] serial_to_ff;
  logic [15:0] trig_to_ff;
  logic        indicator_ff;
  logic        ready_ff;
  logic [31:0] rd_data_ff;
  logic        any_req;
  logic [31:0] idle_lim;
  logic [31:0] stby_lim;
  logic [31:0] off_lim;
  logic [31:0] ind_lim;

  // Widens a count parameter and returns its last cycle index.
  function automatic logic [31:0] last_cyc(input int unsigned n);
    last_cyc = (n == 0) ? 32'h0 : 32'(n - 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a level counts once stages two and three agree.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      scan_sync_ff  <= 3'h7;
      wake_sync_ff  <= 3'h7;
      fault_sync_ff <= 3'h0;
      scan_n_ff     <= 1'b1;
      wake_n_ff     <= 1'b1;
      fault_ff      <= 1'b0;
    end else begin
      scan_sync_ff  <= {scan_sync_ff[1:0], scan_request_n};
      wake_sync_ff  <= {wake_sync_ff[1:0], wake_request_n};
      fault_sync_ff <= {fault_sync_ff[1:0], supply_fault};
      if (scan_sync_ff[1] == scan_sync_ff[2]) begin
        scan_n_ff <= scan_sync_ff[2];
      end
      if (wake_sync_ff[1] == wake_sync_ff[2]) begin
        wake_n_ff <= wake_sync_ff[2];
      end
      if (fault_sync_ff[1] == fault_sync_ff[2]) begin
        fault_ff <= fault_sync_ff[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time-out thresholds are cumulative from the last host activity.
  assign any_req  = !scan_n_ff || !wake_n_ff || serial_cmd_valid;
  assign idle_lim = {16'h0, idle_to_ff};
  assign stby_lim = idle_lim + {16'h0, serial_to_ff};
  assign off_lim  = stby_lim + {16'h0, trig_to_ff};
  assign ind_lim  = trig_wake_ff ? last_cyc(TRIG_DLY_CYC)
                                 : last_cyc(WAKE_DLY_CYC);

  // Millisecond enable pulse for the time-out counter.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      div_cnt_ff <= 32'h0;
      ms_tick_ff <= 1'b0;
    end else if (div_cnt_ff == last_cyc(MS_CYC)) begin
      div_cnt_ff <= 32'h0;
      ms_tick_ff <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 32'h1;
      ms_tick_ff <= 1'b0;
    end
  end

  // Milliseconds since both inputs went high and no command arrived.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      quiet_ms_ff <= 32'h0;
    end else if (any_req || state_ff == PM_POWERUP) begin
      quiet_ms_ff <= 32'h0;
    end else if (ms_tick_ff && quiet_ms_ff != 32'hFFFF_FFFF) begin
      quiet_ms_ff <= quiet_ms_ff + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next power mode.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PM_POWERUP: begin
        if (fault_ff) begin
          nxt_state = PM_POWER_OFF;
        end else if (seq_cnt_ff == last_cyc(GLITCH_CYC)) begin
          nxt_state = PM_ACTIVE;
        end
      end
      PM_ACTIVE: begin
        // Requests here only restart the time-outs.
        if (!any_req && quiet_ms_ff >= idle_lim) begin
          nxt_state = PM_IDLE;
        end
      end
      PM_IDLE: begin
        if (any_req) begin
          nxt_state = PM_ACTIVE;
        end else if (quiet_ms_ff >= stby_lim) begin
          nxt_state = PM_STANDBY;
        end
      end
      PM_STANDBY: begin
        if (any_req) begin
          nxt_state = PM_STBY_EXIT;
        end else if (manual_mode_ff && quiet_ms_ff >= off_lim) begin
          nxt_state = PM_POWER_OFF;
        end
      end
      PM_STBY_EXIT: begin
        if (seq_cnt_ff == last_cyc(STBY_EXIT_CYC)) begin
          nxt_state = PM_ACTIVE;
        end
      end
      PM_POWER_OFF: begin
        if (!scan_n_ff || !wake_n_ff) begin
          nxt_state = PM_OFF_EXIT;
        end else if (serial_cmd_valid) begin
          nxt_state = PM_OFF_EXIT;
        end
      end
      PM_OFF_EXIT: begin
        if (seq_cnt_ff == last_cyc(OFF_EXIT_CYC)) begin
          nxt_state = PM_ACTIVE;
        end
      end
      default: begin
        nxt_state = PM_POWERUP;
      end
    endcase
  end

  // Mode register.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_ff <= PM_POWERUP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Sequence counter restarts on every mode change.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      seq_cnt_ff <= 32'h0;
    end else if (nxt_state != state_ff) begin
      seq_cnt_ff <= 32'h0;
    end else if (seq_cnt_ff != 32'hFFFF_FFFF) begin
      seq_cnt_ff <= seq_cnt_ff + 32'h1;
    end
  end

  // Remembers whether the scan request ended Power Off.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      trig_wake_ff <= 1'b0;
    end else if (state_ff == PM_POWER_OFF && nxt_state == PM_OFF_EXIT) begin
      trig_wake_ff <= !scan_n_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-off indicator: high through Power Off, low after the scan or wake delay.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      indicator_ff <= 1'b0;
    end else if (nxt_state == PM_POWER_OFF) begin
      indicator_ff <= 1'b1;
    end else if (state_ff == PM_OFF_EXIT && seq_cnt_ff == ind_lim) begin
      indicator_ff <= 1'b0;
    end
  end

  // Ready to scan whenever fully powered or idling.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= (nxt_state == PM_ACTIVE) || (nxt_state == PM_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      manual_mode_ff <= CTRL_MANUAL_RST;
      idle_to_ff     <= IDLE_TO_RST;
      serial_to_ff   <= SERIAL_TO_RST;
      trig_to_ff     <= TRIG_TO_RST;
    end else if (bus_req.wr) begin
      if (bus_req.addr == REG_CTRL) begin
        manual_mode_ff <= bus_req.wdata[CTRL_MANUAL_BIT];
      end else if (bus_req.addr == REG_IDLE_TO) begin
        idle_to_ff <= bus_req.wdata[15:0];
      end else if (bus_req.addr == REG_SERIAL_TO) begin
        serial_to_ff <= bus_req.wdata[15:0];
      end else if (bus_req.addr == REG_TRIG_TO) begin
        trig_to_ff <= bus_req.wdata[15:0];
      end
    end
  end

  // Register reads; data stand one cycle, unmapped addresses read zero.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rd_data_ff <= 32'h0;
    end else if (!bus_req.rd) begin
      rd_data_ff <= 32'h0;
    end else if (bus_req.addr == REG_CTRL) begin
      rd_data_ff <= {31'h0, manual_mode_ff};
    end else if (bus_req.addr == REG_IDLE_TO) begin
      rd_data_ff <= {16'h0, idle_to_ff};
    end else if (bus_req.addr == REG_SERIAL_TO) begin
      rd_data_ff <= {16'h0, serial_to_ff};
    end else if (bus_req.addr == REG_TRIG_TO) begin
      rd_data_ff <= {16'h0, trig_to_ff};
    end else if (bus_req.addr == REG_STATUS) begin
      rd_data_ff <= {27'h0, indicator_ff, ready_ff, state_ff};
    end else begin
      rd_data_ff <= 32'h0;
    end
  end

  // Outputs come straight from flip-flops.
  assign rd_data             = rd_data_ff;
  assign power_off_indicator = indicator_ff;
  assign ready_to_scan       = ready_ff;
  assign power_mode          = state_ff;

endmodule

`default_nettype wire

// *** ips_seq_sva.sv ***
// Port assertions for the power-mode sequencer.
`timescale 1ns/1ps
`default_nettype none
module ips_seq_sva
  import ips_pkg::*;
#(
  parameter int unsigned STBY_EXIT_CYC = 5,
  parameter int unsigned OFF_EXIT_CYC  = 40,
  parameter int unsigned TRIG_DLY_CYC  = 12,
  parameter int unsigned WAKE_DLY_CYC  = 10
) (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire ips_bus_s    bus_req,
  input wire logic [31:0] rd_data,
  input wire logic        scan_request_n,
  input wire logic        wake_request_n,
  input wire logic        supply_fault,
  input wire logic        power_off_indicator,
  input wire logic        ready_to_scan,
  input wire logic [2:0]  power_mode
);
  logic [7:0] exit_cnt_ff;
  logic       in_exit;

  // Counts the cycles spent in either exit mode.
  assign in_exit = power_mode == PM_OFF_EXIT || power_mode == PM_STBY_EXIT;
  always_ff @(posedge core_clk) begin
    if (!reset_n || !in_exit) exit_cnt_ff <= 8'h00;
    else exit_cnt_ff <= exit_cnt_ff + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequences of the exit and request steps.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_left(m);
    power_mode == PM_ACTIVE && $past(power_mode) == m;
  endsequence
  sequence s_off_req;
    (power_mode == PM_POWER_OFF && !(scan_request_n && wake_request_n)) [*4];
  endsequence

  AST_FAULT_OFF: assert property (
    (power_mode == PM_POWERUP && supply_fault) [*4]
      |-> ##[0:2] power_mode == PM_POWER_OFF) else $error("no power off");
  AST_IND_OFF: assert property (
    power_mode == PM_POWER_OFF |-> power_off_indicator)
    else $error("indicator low in power off");
  AST_OFF_ENTRY: assert property (
    power_mode == PM_POWER_OFF && $past(power_mode) != PM_POWER_OFF
      |-> $past(power_mode) inside {PM_STANDBY, PM_POWERUP})
    else $error("bad power off entry");
  AST_OFF_WAKE: assert property (
    s_off_req |-> ##[1:2] power_mode == PM_OFF_EXIT)
    else $error("request ignored in power off");
  AST_IND_FALL: assert property (
    $fell(power_off_indicator)
      |-> exit_cnt_ff inside {TRIG_DLY_CYC, WAKE_DLY_CYC})
    else $error("indicator fell at wrong time");
  AST_OFF_EXIT_LEN: assert property (
    s_left(PM_OFF_EXIT) |-> exit_cnt_ff == OFF_EXIT_CYC)
    else $error("power off exit length");
  AST_STBY_EXIT_LEN: assert property (
    s_left(PM_STBY_EXIT) |-> exit_cnt_ff == STBY_EXIT_CYC)
    else $error("standby exit length");
  AST_READY: assert property (
    ready_to_scan == (power_mode == PM_ACTIVE || power_mode == PM_IDLE))
    else $error("ready does not match mode");
  AST_ACTIVE_KEEP: assert property (
    (power_mode == PM_ACTIVE && !(scan_request_n && wake_request_n)) [*5]
      |=> power_mode == PM_ACTIVE && !power_off_indicator)
    else $error("request disturbed active mode");
  AST_STBY_ENTRY: assert property (
    power_mode == PM_STANDBY && $past(power_mode) != PM_STANDBY
      |-> $past(power_mode) == PM_IDLE) else $error("bad standby entry");
  AST_RD_IDLE: assert property (
    !$past(bus_req.rd) |-> rd_data == 32'h0) else $error("stray read data");
endmodule
`default_nettype wire

// *** ips_host_model.sv ***
// Host model that drives the request lines and watches the indicator.
`timescale 1ns/1ps
`default_nettype none
module ips_host_model #(
  parameter int unsigned HOLD_CYC = 8
) (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [1:0] kind,
  input  wire logic       power_off_indicator,
  output logic            scan_request_n,
  output logic            wake_request_n,
  output logic            serial_cmd_valid,
  output logic            ind_seen
);
  int unsigned hold = 0;
  logic [1:0]  sel  = 2'h0;
  logic [1:0]  samp = 2'h0;

  // Lines idle high on their pull-ups; kind 0 scans, 1 wakes, 2 is serial.
  assign scan_request_n   = !(hold != 0 && sel == 2'h0);
  assign wake_request_n   = !(hold != 0 && sel == 2'h1);
  assign serial_cmd_valid = hold == HOLD_CYC && sel == 2'h2;
  always @(posedge core_clk) begin
    if (go) begin
      hold <= HOLD_CYC;
      sel <= kind;
    end else if (hold != 0) begin
      hold <= hold - 1;
    end
  end

  // The indicator edge is slow, so only two agreeing samples move it.
  always @(posedge core_clk) begin
    samp <= {samp[0], power_off_indicator};
    if (samp[1] == samp[0]) ind_seen <= samp[1];
  end
endmodule
`default_nettype wire

// *** ips_power_mode_sequencer_tb_top.sv ***
// Testbench of the power-mode sequencer.
`timescale 1ns/1ps
`default_nettype none
bind ips_power_mode_sequencer ips_seq_sva #(
  .STBY_EXIT_CYC(STBY_EXIT_CYC), .OFF_EXIT_CYC(OFF_EXIT_CYC),
  .TRIG_DLY_CYC(TRIG_DLY_CYC), .WAKE_DLY_CYC(WAKE_DLY_CYC)
) u_sva (.core_clk(core_clk), .reset_n(reset_n), .bus_req(bus_req),
  .rd_data(rd_data), .scan_request_n(scan_request_n),
  .wake_request_n(wake_request_n), .supply_fault(supply_fault),
  .power_off_indicator(power_off_indicator),
  .ready_to_scan(ready_to_scan), .power_mode(power_mode));
module ips_power_mode_sequencer_tb_top
  import ips_pkg::*;
;
  localparam int unsigned SE = 5;
  localparam int unsigned OE = 40;
  localparam int unsigned TD = 12;
  localparam int unsigned WD = 10;
  localparam int unsigned MS = 4;
  // Time-outs in ms written by the bench.
  // The quiet timer runs through an exit from Power Off, so the idle time-out
  // is kept longer than that exit, or ACTIVE would fall straight back down.
  localparam logic [15:0] TO_IDLE = 16'h0018;
  localparam logic [15:0] TO_SER  = 16'h0002;
  localparam logic [15:0] TO_TRIG = 16'h0002;
  localparam int unsigned QUIET   = (TO_IDLE + TO_SER + TO_TRIG) * MS;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        supply_fault = 1'b0;
  logic        go = 1'b0;
  logic [1:0]  kind = 2'h0;
  ips_bus_s    bus_req = '0;
  logic [31:0] rd_data;
  logic        scan_n, wake_n, ser_v, ind, ready, ind_seen;
  logic [2:0]  mode;
  int          error_cnt = 0;
  int          tests_run = 0;

  // Free-running core clock.
  always #20 core_clk = !core_clk;

  ips_power_mode_sequencer #(.GLITCH_CYC(20), .STBY_EXIT_CYC(SE),
    .OFF_EXIT_CYC(OE), .TRIG_DLY_CYC(TD), .WAKE_DLY_CYC(WD),
    .MS_CYC(MS)) dut (.core_clk(core_clk), .reset_n(reset_n),
    .bus_req(bus_req), .rd_data(rd_data), .scan_request_n(scan_n),
    .wake_request_n(wake_n), .supply_fault(supply_fault),
    .serial_cmd_valid(ser_v), .power_off_indicator(ind),
    .ready_to_scan(ready), .power_mode(mode));
  ips_host_model host_m (.core_clk(core_clk), .go(go), .kind(kind),
    .power_off_indicator(ind), .scan_request_n(scan_n),
    .wake_request_n(wake_n), .serial_cmd_valid(ser_v), .ind_seen(ind_seen));

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers for timing, comparison, bus and host requests.
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic bus(logic [7:0] a, logic [31:0] d, logic w);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge core_clk);
    bus_req <= '0;
  endtask
  task automatic rd_chk(string what, logic [7:0] a, logic [31:0] exp);
    bus(a, 32'h0, 1'b0);
    #1;
    chk(what, exp, rd_data);
  endtask
  task automatic host(logic [1:0] k);
    @(posedge core_clk);
    go <= 1'b1;
    kind <= k;
    @(posedge core_clk);
    go <= 1'b0;
    #1;
  endtask
  task automatic wait_mode(logic [2:0] m, int bound, output int n);
    n = 0;
    while (mode !== m) begin
      tick();
      n++;
      if (n > bound) begin
        chk("mode wait", m, mode);
        end_of_test();
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic exit_seq(logic [1:0] k, logic [2:0] from, int fall, int len);
    int n;
    int fell_at;
    logic [2:0] exit_m;
    fell_at = 0;
    exit_m = (from == PM_STANDBY) ? PM_STBY_EXIT : PM_OFF_EXIT;
    chk("start mode", from, mode);
    host(k);
    wait_mode(exit_m, 12, n);
    n = 0;
    while (mode === exit_m && n < 60) begin
      tick();
      n++;
      if (fell_at == 0 && ind === 1'b0) fell_at = n;
    end
    chk("indicator fall", fall, fell_at);
    chk("exit length", len, n);
    chk("mode after exit", PM_ACTIVE, mode);
    chk("ready", 1'b1, ready);
  endtask
  task automatic t_fault();
    int n;
    wait_mode(PM_POWER_OFF, 10, n);
    chk("indicator", 1'b1, ind);
    supply_fault <= 1'b0;
    exit_seq(2'h2, PM_POWER_OFF, WD, OE);
  endtask
  task automatic t_regs();
    rd_chk("ctrl", 8'h00, 32'h1);
    rd_chk("idle", 8'h04, 32'h3E8);
    rd_chk("serial", 8'h08, 32'hBB8);
    rd_chk("trig", 8'h0C, 32'hBB8);
    rd_chk("unmapped", 8'h14, 32'h0);
    bus(8'h04, {16'h0, TO_IDLE}, 1'b1);
    bus(8'h08, {16'h0, TO_SER}, 1'b1);
    bus(8'h0C, {16'h0, TO_TRIG}, 1'b1);
    rd_chk("idle back", 8'h04, {16'h0, TO_IDLE});
    rd_chk("serial back", 8'h08, {16'h0, TO_SER});
    rd_chk("trig back", 8'h0C, {16'h0, TO_TRIG});
  endtask
  task automatic t_down();
    int n;
    int total;
    host(2'h1);
    wait_mode(PM_ACTIVE, 60, n);
    host(2'h1);
    repeat (4) tick();
    repeat (4) begin
      tick();
      chk("mode", PM_ACTIVE, mode);
      chk("indicator", 1'b0, ind);
    end
    rd_chk("status", 8'h10, 32'h9);
    total = 10;
    wait_mode(PM_IDLE, 200, n);
    total += n;
    wait_mode(PM_STANDBY, 60, n);
    total += n;
    wait_mode(PM_POWER_OFF, 60, n);
    total += n;
    // The pins rise 8 cycles into the count; synchronising adds a few more.
    chk("off delay", 1'b1, total >= QUIET + 8 && total <= QUIET + 8 + 2 * MS);
    repeat (4) tick();
    chk("filtered indicator", 1'b1, ind_seen);
  endtask
  task automatic t_no_off();
    int n;
    bus(8'h00, 32'h0, 1'b1);
    exit_seq(2'h1, PM_POWER_OFF, WD, OE);
    wait_mode(PM_STANDBY, 120, n);
    repeat (40) tick();
    chk("stays standby", PM_STANDBY, mode);
    exit_seq(2'h1, PM_STANDBY, 1, SE);
  endtask

  // Reset, then run every scenario in turn.
  initial begin
    int n;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    supply_fault <= 1'b1;
    t_fault();
    t_regs();
    t_down();
    exit_seq(2'h0, PM_POWER_OFF, TD, OE);
    wait_mode(PM_POWER_OFF, 120, n);
    t_no_off();
    end_of_test();
  end
endmodule
`default_nettype wire
